// ===== design/qspsq_sck_gen.sv
/*
 * serial clock phase timer for the queued sequencer. produces a one-cycle
 * tick at each half serial period while enabled. assumes divider >= 1.
 */
`timescale 1ns/1ps
module qspsq_sck_gen (
    input  wire logic       mclk,     // system clock
    input  wire logic       sys_rst,  // sync reset, high
    input  wire logic       run,      // count while high
    input  wire logic [7:0] divider,  // half period in clocks
    output logic            tick      // half period elapsed
);
    import qspsq_pkg::*;

    logic [7:0] cnt_r;

    // ==========================================================
    // half period counter; divider of zero treated as one
    always_ff @(posedge mclk) begin
        if (sys_rst || !run) begin
            cnt_r <= 8'hFF;  // first tick lands on the first enabled edge
        end else if (cnt_r >= divider) begin
            cnt_r <= 8'h01;
        end else begin
            cnt_r <= cnt_r + 8'h01;
        end
    end

    assign tick = run && (cnt_r >= divider);
endmodule

// ===== design/qspsq_top.sv
/*
 * queued spi master sequencer: walks a 16-entry queue of transmit and receive words
 * and command bytes, driving selects, serial clock and data out.
 * assumes miso comes from a pin and is synchronised here; registers are
 * reached over a plain strobe port with read data one cycle later.
 */
// Implementation choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module qspsq_top (
    input  wire logic                 mclk,      // system clock
    input  wire logic                 sys_rst,   // sync reset, high
    input  wire qspsq_pkg::qspsq_bus_t bus,      // register request
    output logic [15:0]               rdata,     // read data, next cycle
    input  wire logic                 miso,      // serial in pin
    output qspsq_pkg::qspsq_pins_t    pins,      // selects, clock, data
    output logic                      irq        // level interrupt
);
    import qspsq_pkg::*;

    // ==========================================================
    // configuration registers
    logic [7:0]  div_r;
    logic [4:0]  bits_r;
    logic        clock_idle_level_r;
    logic        clock_sample_edge_select_r;
    logic [3:0]  defsel_r;
    logic [7:0]  lead_r;
    logic [7:0]  trail_r;
    logic [3:0]  first_r;
    logic [3:0]  last_r;
    logic        wrap_enable_r;
    logic        wrap_target_select_r;
    logic        run_r;
    logic        ien_r;
    logic        done_r;
    logic [3:0]  cpt_r;
    logic        new_q_r;

    logic [15:0] tx_mem [QDEPTH];
    logic [15:0] rx_mem [QDEPTH];
    logic [7:0]  cmd_mem [QDEPTH];

    qspsq_state_t state_r;
    logic [3:0]  idx_r;
    logic [15:0] cnt_r;
    logic [4:0]  bitn_r;
    logic        phase_r;
    logic [15:0] sh_r;
    logic [3:0]  sel_r;
    logic        sck_r;
    logic        mosi_r;
    logic        miso_s1_r;
    logic        miso_s2_r;
    logic        entry_done;
    logic        tick;
    logic [4:0]  len;
    logic [7:0]  cmd;
    logic [15:0] lead_tgt;

    wire wr_hit = bus.wr;
    assign cmd = cmd_mem[idx_r];
    assign len = cmd[CMD_WLEN] ? bits_r : DEF_BITS;
    // lead in system clocks: programmed count, or half a serial period
    assign lead_tgt = cmd[CMD_LEAD] ? {8'h00, lead_r} : {8'h00, div_r};

    // ==========================================================
    // miso synchroniser, two stages before any use
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            miso_s1_r <= 1'b0;
            miso_s2_r <= 1'b0;
        end else begin
            miso_s1_r <= miso;
            miso_s2_r <= miso_s1_r;
        end
    end

    qspsq_sck_gen u_sck (
        .mclk    (mclk),
        .sys_rst (sys_rst),
        .run     (state_r == S_SHIFT || state_r == S_TAIL),
        .divider (div_r),
        .tick    (tick)
    );

    // ==========================================================
    // control register writes
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_r    <= RST_DIV;
            bits_r   <= RST_BITS;
            clock_idle_level_r   <= 1'b0;
            clock_sample_edge_select_r   <= 1'b0;
            defsel_r <= RST_DEF_SEL;
            lead_r   <= RST_LEAD;
            trail_r  <= RST_TRAIL;
            first_r  <= 4'h0;
            last_r   <= 4'h0;
            wrap_enable_r   <= 1'b0;
            wrap_target_select_r   <= 1'b0;
            ien_r    <= 1'b0;
        end else if (wr_hit) begin
            case (bus.addr)
                OFS_CTRL: begin
                    div_r    <= bus.wdata[7:0];
                    bits_r   <= bus.wdata[12:8];
                    clock_idle_level_r   <= bus.wdata[13];
                    clock_sample_edge_select_r   <= bus.wdata[14];
                end
                OFS_DELAY: begin
                    lead_r   <= bus.wdata[7:0];
                    trail_r  <= bus.wdata[15:8];
                end
                OFS_QUEUE: begin
                    first_r  <= bus.wdata[3:0];
                    last_r   <= bus.wdata[7:4];
                    wrap_enable_r   <= bus.wdata[8];
                    wrap_target_select_r   <= bus.wdata[9];
                    defsel_r <= bus.wdata[15:12];
                end
                OFS_IRQ_EN: ien_r <= bus.wdata[0];
                default: ;
            endcase
        end
    end

    // ==========================================================
    // transmit and command memories written by software; receive by the shifter only
    always_ff @(posedge mclk) begin
        if (wr_hit && bus.addr[5:4] == OFS_TXRAM[5:4]) begin
            tx_mem[bus.addr[3:0]] <= bus.wdata;
        end
        if (wr_hit && bus.addr[5:4] == OFS_CMRAM[5:4]) begin
            cmd_mem[bus.addr[3:0]] <= bus.wdata[7:0];
        end
    end

    // receive slot of the executing entry, lsb justified
    always_ff @(posedge mclk) begin
        if (entry_done) begin
            rx_mem[idx_r] <= sh_r & ((16'h0001 << len) - 16'h0001);
        end
    end

    // ==========================================================
    // run enable: software starts or stops, hardware clears at the end when wrap is off
    wire wrap_end = entry_done && (idx_r == last_r);
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            run_r   <= 1'b0;
            new_q_r <= 1'b0;
        end else if (wr_hit && bus.addr == OFS_QUEUE) begin
            run_r   <= bus.wdata[10];
            new_q_r <= bus.wdata[10];
        end else begin
            if (wrap_end && !wrap_enable_r) begin
                run_r <= 1'b0;
            end
            if (state_r == S_LEAD) begin
                new_q_r <= 1'b0;
            end
        end
    end

    // ==========================================================
    // status: completed pointer and sticky done flag
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cpt_r  <= 4'h0;
            done_r <= 1'b0;
        end else begin
            if (entry_done) begin
                cpt_r <= idx_r;
            end
            if (wrap_end) begin
                done_r <= 1'b1;
            end else if (wr_hit && bus.addr == OFS_IRQ_CL && bus.wdata[0]) begin
                done_r <= 1'b0;  // set above wins over clear
            end
        end
    end

    assign irq = done_r && ien_r;

    // ==========================================================
    // sequencer state machine
    assign entry_done = (state_r == S_TRAIL) && (cnt_r <= MIN_COUNT);

    always_ff @(posedge mclk) begin
        if (sys_rst || !run_r) begin
            state_r <= S_IDLE;  // stop at once
            idx_r   <= 4'h0;
            cnt_r   <= MIN_COUNT;
            bitn_r  <= 5'h00;
            phase_r <= 1'b0;
            sh_r    <= 16'h0000;
        end else begin
            case (state_r)
                S_IDLE: begin
                    idx_r   <= first_r;
                    state_r <= S_LEAD;
                    cnt_r   <= MIN_COUNT;
                end
                S_LEAD: begin
                    sh_r    <= tx_mem[idx_r];
                    bitn_r  <= 5'h00;
                    phase_r <= 1'b0;
                    // count clocks, or half period
                    // first shift edge moves the clock off its idle level at once
                    if (cnt_r >= lead_tgt) begin
                        state_r <= S_SHIFT;
                    end else begin
                        cnt_r <= cnt_r + 16'h0001;
                    end
                end
                S_SHIFT: begin
                    if (tick) begin
                        phase_r <= !phase_r;
                        if (!phase_r) begin
                            // sample edge: capture miso into the top
                            sh_r <= {miso_s2_r, sh_r[15:1]};
                        end else if (bitn_r == len - 5'h01) begin
                            state_r <= S_TAIL;
                        end else begin
                            bitn_r <= bitn_r + 5'h01;
                        end
                    end
                end
                S_TAIL: begin
                    // half period before selects may change
                    if (tick) begin
                        state_r <= S_TRAIL;
                        cnt_r   <= cmd[CMD_TRAIL]
                                   ? ({8'h00, trail_r} * TRAIL_MULT)
                                   : MIN_COUNT;
                        sh_r    <= sh_r >> (5'h10 - len);
                    end
                end
                S_TRAIL: begin
                    if (cnt_r <= MIN_COUNT) begin
                        state_r <= S_NEXT;
                    end else begin
                        cnt_r <= cnt_r - 16'h0001;
                    end
                end
                S_NEXT: begin
                    state_r <= S_LEAD;
                    cnt_r   <= MIN_COUNT;
                    if (idx_r == last_r) begin
                        idx_r <= wrap_target_select_r ? first_r : 4'h0;
                    end else begin
                        idx_r <= idx_r + 4'h1;
                    end
                end
                default: state_r <= S_IDLE;
            endcase
        end
    end

    // ==========================================================
    // pin drivers from flip-flops
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            sel_r  <= RST_DEF_SEL;
            sck_r  <= 1'b0;
            mosi_r <= 1'b0;
        end else begin
            if (state_r == S_SHIFT && tick) begin
                sck_r <= !sck_r;
            end else if (state_r != S_SHIFT) begin
                sck_r <= clock_idle_level_r;  // idle level
            end
            // data out changes on the trailing edge, valid at sample edge
            if (state_r == S_LEAD) begin
                mosi_r <= tx_mem[idx_r][bitn_r[3:0]];
            end else if (state_r == S_SHIFT && tick && phase_r) begin
                mosi_r <= tx_mem[idx_r][bitn_r[3:0] + 4'h1];
            end
            if (state_r == S_LEAD) begin
                sel_r <= cmd[3:0];
            end else if ((state_r == S_TRAIL || state_r == S_IDLE) &&
                         !(cmd[CMD_HOLD] && run_r)) begin
                sel_r <= defsel_r;
            end
        end
    end

    assign pins.sel  = sel_r;
    assign pins.sck  = sck_r;
    assign pins.mosi = mosi_r;

    // ==========================================================
    // register reads, data in the cycle after the strobe
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            rdata <= 16'h0000;
        end else if (bus.rd) begin
            case (bus.addr[5:4])
                OFS_TXRAM[5:4]: rdata <= tx_mem[bus.addr[3:0]];
                OFS_RXRAM[5:4]: rdata <= rx_mem[bus.addr[3:0]];
                OFS_CMRAM[5:4]: rdata <= {8'h00, cmd_mem[bus.addr[3:0]]};
                default: begin
                    case (bus.addr)
                        OFS_CTRL:   rdata <= {1'b0, clock_sample_edge_select_r, clock_idle_level_r,
                                              bits_r, div_r};
                        OFS_DELAY:  rdata <= {trail_r, lead_r};
                        OFS_QUEUE:  rdata <= {defsel_r, 1'b0, run_r,
                                              wrap_target_select_r, wrap_enable_r,
                                              last_r, first_r};
                        OFS_STATUS: rdata <= {8'h00, done_r, 3'h0, cpt_r};
                        OFS_IRQ_EN: rdata <= {15'h0000, ien_r};
                        default:    rdata <= 16'h0000;
                    endcase
                end
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule

// ===== pkg/qspsq_pkg.sv
/*
 * holds the shared constants, types and register map of the queued serial
 * sequencer. assumes a single 100 MHz system clock and the plain register
 * port of the sequencer top.
 */
package qspsq_pkg;

    // ==========================================================
    // sizes
    localparam int QDEPTH = 16;
    localparam int AW     = 6;

    // ==========================================================
    // register offsets
    localparam logic [5:0] OFS_CTRL   = 6'h00;  // divider, length, polarity
    localparam logic [5:0] OFS_DELAY  = 6'h01;  // delay_control_register
    localparam logic [5:0] OFS_QUEUE  = 6'h02;  // pointers, wrap, run
    localparam logic [5:0] OFS_STATUS = 6'h03;  // serial_status_register
    localparam logic [5:0] OFS_IRQ_EN = 6'h04;
    localparam logic [5:0] OFS_IRQ_CL = 6'h05;
    localparam logic [5:0] OFS_TXRAM  = 6'h10;
    localparam logic [5:0] OFS_RXRAM  = 6'h20;
    localparam logic [5:0] OFS_CMRAM  = 6'h30;

    // ==========================================================
    // reset values and fixed counts
    localparam logic [7:0]  RST_DIV      = 8'h04;
    localparam logic [4:0]  RST_BITS     = 5'h08;
    localparam logic [4:0]  DEF_BITS     = 5'h08;
    localparam logic [7:0]  RST_LEAD     = 8'h04;
    localparam logic [7:0]  RST_TRAIL    = 8'h04;
    localparam logic [3:0]  RST_DEF_SEL  = 4'hF;
    localparam logic [15:0] TRAIL_MULT   = 16'h0020;  // 32 clocks per unit
    localparam logic [15:0] MIN_COUNT    = 16'h0001;

    // command byte fields
    localparam int CMD_HOLD  = 7;
    localparam int CMD_WLEN  = 6;
    localparam int CMD_TRAIL = 5;
    localparam int CMD_LEAD  = 4;

    typedef enum logic [5:0] {
        S_IDLE  = 6'b000001,
        S_LEAD  = 6'b000010,
        S_SHIFT = 6'b000100,
        S_TAIL  = 6'b001000,
        S_TRAIL = 6'b010000,
        S_NEXT  = 6'b100000
    } qspsq_state_t;

    typedef struct packed {
        logic [3:0] sel;
        logic       sck;
        logic       mosi;
    } qspsq_pins_t;

    typedef struct packed {
        logic [AW-1:0] addr;
        logic [15:0]   wdata;
        logic          wr;
        logic          rd;
    } qspsq_bus_t;

endpackage

// ===== testbench/qspsq_bench.sv
/* self-checking bench for the queue sequencer top.
   assumes one slave on select 0 and mode 0 timing. */
`timescale 1ns/1ps
module qspsq_bench;
    import qspsq_pkg::*;
    typedef struct {
        logic [3:0]  idx;
        logic [7:0]  cmd;
        logic [15:0] tx;
        logic [15:0] rep;
        int          bits;
        int          lead;
    } qspsq_row_t;
    logic        mclk;
    logic        sys_rst;
    qspsq_bus_t  bus;
    logic [15:0] rdata;
    logic [15:0] reply;
    logic [15:0] heard;
    logic        miso;
    logic        irq;
    qspsq_pins_t pins;
    int          nbits;
    int          bad_count;
    int          check_count;
    int          cyc, t_sel, t_rel, lead_cyc, gap_cyc, rises;
    logic        sel_q, sck_q, armed;
    logic [15:0] hq[$];
    qspsq_row_t  rows[3];
    qspsq_top dut (.mclk(mclk), .sys_rst(sys_rst), .bus(bus),
        .rdata(rdata), .miso(miso), .pins(pins), .irq(irq));
    qspsq_slave u_slave (.sck(pins.sck), .cs_n(pins.sel[0]),
        .mosi(pins.mosi), .reply(reply), .miso(miso), .heard(heard),
        .nbits(nbits));
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // ==========================================
    // frame monitor: lead time, gap, frame count and the word heard in each frame
    always @(posedge mclk) begin
        cyc = cyc + 1;
        if (pins.sel[0] && !sel_q) begin
            rises = rises + 1;
            t_rel = cyc;
            hq.push_back(heard);
        end
        if (!pins.sel[0] && sel_q) begin
            gap_cyc = cyc - t_rel;
            t_sel = cyc;
            armed = 1'b1;
        end
        if (pins.sck && !sck_q && armed) begin
            lead_cyc = cyc - t_sel;
            armed = 1'b0;
        end
        sel_q = pins.sel[0];
        sck_q = pins.sck;
    end
    // ==========================================
    // bus cycles and compares
    task automatic wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge mclk);
        bus.addr <= a;
        bus.wdata <= d;
        bus.wr <= 1'b1;
        @(posedge mclk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge mclk);
        bus.addr <= a;
        bus.rd <= 1'b1;
        @(posedge mclk);
        bus.rd <= 1'b0;
        #1 d = rdata;
    endtask
    task automatic chk_w(input string n, input logic [15:0] e,
                         input logic [15:0] g);
        check_count++;
        if (g !== e) begin
            bad_count++;
            $display("FAIL %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic chk_i(input string n, input int e, input int g);
        check_count++;
        if (g != e) begin
            bad_count++;
            $display("FAIL %s expected %0d seen %0d", n, e, g);
        end
    endtask
    task automatic chk_r(input string n, input logic [5:0] a,
                         input logic [15:0] m, input logic [15:0] e);
        logic [15:0] v;
        rd(a, v);
        chk_w(n, e, v & m);
    endtask
    // polling bounded: a stuck queue falls through to the compares
    task automatic wait_done();
        logic [15:0] v;
        v = 16'h0000;
        for (int k = 0; k < 300 && !v[7]; k++) rd(OFS_STATUS, v);
    endtask
    function automatic logic [15:0] qword(input logic [3:0] f,
        input logic [3:0] l, input logic w, input logic t);
        return {4'hF, 1'b0, 1'b1, t, w, l, f};
    endfunction
    task automatic run_wrap(input logic [3:0] f, input logic [3:0] l,
                            input logic t);
        logic [3:0] e;
        int n;
        hq.delete();
        wr(OFS_IRQ_EN, 16'h0001);
        wr(OFS_QUEUE, qword(f, l, 1'b1, t));
        for (int k = 0; k < 3000 && hq.size() < 7; k++) @(posedge mclk);
        chk_w("irq", 16'h0001, {15'h0000, irq});
        chk_r("run", OFS_QUEUE, 16'h0400, 16'h0400);
        wr(OFS_QUEUE, qword(f, l, 1'b1, t) & 16'hFBFF);
        repeat (3) @(posedge mclk);
        #1 chk_w("stop", 16'h000F, {11'h000, pins.sck, pins.sel});
        n = hq.size();
        repeat (200) @(posedge mclk);
        chk_i("frames", n, hq.size());
        e = f;
        for (int k = 0; k < 7; k++) begin
            chk_w("entry", {8'h00, 4'hA, e}, hq[k]);
            e = (e == l) ? (t ? f : 4'h0) : e + 4'h1;
        end
        wr(OFS_IRQ_CL, 16'h0001);
        chk_r("done", OFS_STATUS, 16'h0080, 16'h0000);
        chk_w("irq", 16'h0000, {15'h0000, irq});
        wr(OFS_IRQ_EN, 16'h0000);
    endtask
    task automatic run_pair(input logic [7:0] c, input int fr);
        int r0;
        r0 = rises;
        wr(OFS_CMRAM | 6'h08, {8'h00, c});
        wr(OFS_QUEUE, qword(4'h8, 4'h9, 1'b0, 1'b0));
        wait_done();
        chk_i("frames", fr, rises - r0);
        wr(OFS_IRQ_CL, 16'h0001);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // whole run is a few thousand cycles; this is ample
    initial begin
        repeat (20000) @(posedge mclk);
        bad_count++;
        conclude();
    end
    // ==========================================
    // main sequence
    initial begin
        logic [15:0] m;
        bus = '0;
        sys_rst = 1'b1;
        reply = 16'h0000;
        {cyc, t_sel, t_rel, lead_cyc, gap_cyc, rises} = '0;
        {sel_q, sck_q, armed} = 3'b100;
        {bad_count, check_count} = '0;
        rows = '{'{4'h3, 8'h0E, 16'h00A5, 16'h003C, 8, 3},
                 '{4'h7, 8'h7E, 16'h02D3, 16'h0359, 10, 5},
                 '{4'hF, 8'h4E, 16'h0155, 16'h02AA, 10, 3}};
        repeat (16) @(posedge mclk);
        sys_rst <= 1'b0;
        wr(6'h08, 16'hFFFF);
        chk_r("ctrl", OFS_CTRL, 16'h7FFF, {3'b000, RST_BITS, RST_DIV});
        chk_r("delay", OFS_DELAY, 16'hFFFF, {RST_TRAIL, RST_LEAD});
        chk_r("queue", OFS_QUEUE, 16'hF7FF, {RST_DEF_SEL, 12'h000});
        chk_r("status", OFS_STATUS, 16'h008F, 16'h0000);
        chk_r("irq_en", OFS_IRQ_EN, 16'h0001, 16'h0000);
        chk_r("unmapped", 6'h08, 16'hFFFF, 16'h0000);
        wr(OFS_CTRL, 16'h0A03);
        wr(OFS_DELAY, 16'h0205);
        // one single-entry queue per row
        foreach (rows[i]) begin
            m = 16'((32'h1 << rows[i].bits) - 32'h1);
            reply = rows[i].rep;
            wr(OFS_TXRAM | 6'(rows[i].idx), rows[i].tx);
            wr(OFS_CMRAM | 6'(rows[i].idx), {8'h00, rows[i].cmd});
            wr(OFS_QUEUE, qword(rows[i].idx, rows[i].idx, 1'b0, 1'b0));
            wait_done();
            chk_r("status", OFS_STATUS, 16'h008F,
                  {8'h00, 4'h8, rows[i].idx});
            chk_r("run", OFS_QUEUE, 16'h0400, 16'h0000);
            chk_r("rx", OFS_RXRAM | 6'(rows[i].idx), 16'hFFFF,
                  rows[i].rep & m);
            chk_w("mosi", rows[i].tx & m, heard);
            chk_i("bits", rows[i].bits, nbits);
            chk_i("lead", rows[i].lead, lead_cyc);
            chk_w("irq", 16'h0000, {15'h0000, irq});
            wr(OFS_IRQ_CL, 16'h0001);
        end
        // tagged words so the slave log names each entry
        for (int k = 0; k < 16; k++) begin
            wr(OFS_TXRAM | 6'(k), {8'h00, 4'hA, 4'(k)});
            wr(OFS_CMRAM | 6'(k), 16'h000E);
        end
        run_wrap(4'hF, 4'h2, 1'b0);
        run_wrap(4'h5, 4'h6, 1'b1);
        run_pair(8'h8E, 1);
        run_pair(8'h2E, 2);
        chk_i("trail", 1, int'(gap_cyc >= 64 && gap_cyc <= 67));
        // reset in mid-run: pins idle, run enable cleared
        wr(OFS_QUEUE, qword(4'h8, 4'h9, 1'b0, 1'b0));
        repeat (30) @(posedge mclk);
        sys_rst <= 1'b1;
        repeat (2) @(posedge mclk);
        sys_rst <= 1'b0;
        #1 chk_w("rst_pins", 16'h000F, {11'h000, pins.sck, pins.sel});
        chk_r("rst_run", OFS_QUEUE, 16'h0400, 16'h0000);
        chk_w("rst_irq", 16'h0000, {15'h0000, irq});
        conclude();
    end
endmodule

// ===== testbench/qspsq_props.sv
/* port checker for the queue sequencer top.
   assumes mode 0 and a divider changed only while idle. */
`timescale 1ns/1ps
module qspsq_props (
    input wire logic                   mclk,    // system clock
    input wire logic                   sys_rst, // sync reset
    input wire qspsq_pkg::qspsq_bus_t  bus,     // register request
    input wire logic [15:0]            rdata,   // read data
    input wire logic                   miso,    // serial in
    input wire qspsq_pkg::qspsq_pins_t pins,    // serial pins
    input wire logic                   irq      // interrupt
);
    import qspsq_pkg::*;
    logic [7:0] div_r;
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    logic       en_r;
    logic       stop_r;
    logic [7:0] half;
    // ==========================================
    // snooped settings; divider 0 acts as 1
    assign half = (div_r == 8'h00) ? 8'h01 : div_r;
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            div_r <= RST_DIV;
            en_r <= 1'b0;
            stop_r <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == OFS_CTRL) div_r <= bus.wdata[7:0];
            if (bus.addr == OFS_IRQ_EN) en_r <= bus.wdata[0];
            // software stop may cut a phase short
            if (bus.addr == OFS_QUEUE) stop_r <= !bus.wdata[10];
        end
    end
    // phase lengths, saturating so long idles stay legal
    always_ff @(posedge mclk) begin
        if (sys_rst || !pins.sck) hi_r <= 8'h00;
        else if (hi_r != 8'hFF) hi_r <= hi_r + 8'h01;
        if (sys_rst) lo_r <= 8'hFF;
        else if (pins.sck) lo_r <= 8'h00;
        else if (lo_r != 8'hFF) lo_r <= lo_r + 8'h01;
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (sys_rst);
    // ==========================================
    // assertions
    a_rdata_quiet: assert property (
        !$past(bus.rd) |-> rdata == 16'h0000)
        else $error("read data outside its slot");
    a_irq_masked: assert property (
        !en_r && !$past(en_r) |-> !irq)
        else $error("interrupt while disabled");
    a_sck_high: assert property (
        $fell(pins.sck) && !stop_r |-> hi_r == half)
        else $error("serial clock high phase wrong");
    a_sck_low: assert property (
        $rose(pins.sck) |-> lo_r >= half)
        else $error("serial clock low phase short");
    a_sel_tail: assert property (
        $changed(pins.sel) && !stop_r |-> !pins.sck && lo_r >= half)
        else $error("selects moved too soon");
    a_sck_idle: assert property (
        pins.sel == 4'hF && !stop_r |-> !pins.sck)
        else $error("serial clock not idle low");
    a_mosi_setup: assert property (
        $rose(pins.sck) |-> $stable(pins.mosi))
        else $error("data moved at rising edge");
    a_mosi_fall: assert property (
        $changed(pins.mosi) && !stop_r |-> !pins.sck)
        else $error("data moved while clock high");
    c_frame: cover property ($fell(pins.sel[0]));
    c_phase: cover property ($fell(pins.sck) && hi_r == half);
    c_irq: cover property ($rose(irq));
endmodule
bind qspsq_top qspsq_props u_props (.mclk(mclk), .sys_rst(sys_rst),
    .bus(bus), .rdata(rdata), .miso(miso), .pins(pins), .irq(irq));

// ===== testbench/qspsq_slave.sv
/* behavioural serial slave, mode 0, lsb first.
   assumes its select is low while addressed. */
`timescale 1ns/1ps
module qspsq_slave (
    input  wire logic        sck,   // serial clock
    input  wire logic        cs_n,  // select, low active
    input  wire logic        mosi,  // data from master
    input  wire logic [15:0] reply, // word sent back
    output logic             miso,  // data to master
    output logic [15:0]      heard, // word taken in
    output int               nbits  // bits this frame
);
    logic [15:0] sh_r;
    // ==========================================
    // frame start puts the first bit out at once
    initial begin
        miso = 1'b0;
        heard = 16'h0000;
        nbits = 0;
    end
    always @(negedge cs_n) begin
        sh_r = reply;
        heard = 16'h0000;
        nbits = 0;
        miso = reply[0];
    end
    // take on rising, move on falling
    always @(posedge sck) begin
        if (!cs_n && nbits < 16) begin
            heard[nbits] = mosi;
            nbits = nbits + 1;
        end
    end
    always @(negedge sck) begin
        if (!cs_n) begin
            sh_r = sh_r >> 1;
            miso = sh_r[0];
        end
    end
    // released line has no pull: show the opposite of the last bit
    always @(posedge cs_n) miso = ~miso;
endmodule
